/* File: common/pbl_pkg.sv */
// package for the prefetch buffer look-up block
package pbl_pkg;
  // slot states: empty, waiting for arbiter ack, data landed
  typedef enum logic [1:0] {
    PBL_SLOT_EMPTY = 2'b00,
    PBL_SLOT_WAIT = 2'b01,
    PBL_SLOT_LANDED = 2'b10
  } pbl_slot_t;

  // look-up classification
  typedef enum logic [1:0] {
    PBL_CLS_NONE = 2'b00,
    PBL_CLS_HIT = 2'b01,
    PBL_CLS_HIT_WAIT = 2'b10,
    PBL_CLS_MISS = 2'b11
  } pbl_cls_t;

  // request controller states
  typedef enum logic [1:0] {
    PBL_ST_IDLE = 2'b00,
    PBL_ST_HIT_STALL = 2'b01,
    PBL_ST_HOLD = 2'b10
  } pbl_state_t;

  // submit kinds toward the bank
  typedef enum logic [1:0] {
    PBL_SUB_NONE = 2'b00,
    PBL_SUB_UNCOND = 2'b01,
    PBL_SUB_COND = 2'b10
  } pbl_sub_t;

  localparam int PBL_AW = 32;
  localparam int PBL_DW = 256;
  localparam int PBL_SLOTS = 4;
  localparam int PBL_OWIDTH = 4;
  // one 256-bit word is 32 bytes
  localparam logic [PBL_AW-1:0] PBL_WORD_STEP = 32'h0000_0020;
  localparam logic [PBL_AW-1:0] PBL_ADDR_RST = 32'h0000_0000;
  localparam logic [PBL_OWIDTH-1:0] PBL_CNT_RST = 4'h0;

  // incoming command from the l2 controller
  typedef struct packed {
    logic valid;
    logic write;
    logic pf_able;
    logic [PBL_AW-1:0] addr;
  } pbl_cmd_t;

  // request toward the bank arbiters
  typedef struct packed {
    logic valid;
    pbl_sub_t kind;
    logic [PBL_AW-1:0] addr;
  } pbl_breq_t;

  // priority upgrade of a pending prefetch
  typedef struct packed {
    logic valid;
    logic cond;
    logic [PBL_AW-1:0] addr;
  } pbl_upg_t;
endpackage

/* File: hdl/pbl_lookup.sv */
// prefetch buffer look-up and fetch logic for one processor
`timescale 1ns/1ps
`default_nettype none
module pbl_lookup #(
  parameter int SLOTS = pbl_pkg::PBL_SLOTS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire pbl_pkg::pbl_cmd_t cmd,
  input wire logic prefetch_flush_control,
  input wire logic bank_busy,
  input wire logic pf_issue,
  input wire logic ack,
  input wire logic ack_real,
  input wire logic [pbl_pkg::PBL_DW-1:0] ack_data,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [pbl_pkg::PBL_DW-1:0] rd_data,
  output pbl_pkg::pbl_breq_t breq,
  output pbl_pkg::pbl_upg_t upg,
  output logic pf_cancel,
  output logic pf_active,
  output logic [pbl_pkg::PBL_AW-1:0] pf_addr,
  output pbl_pkg::pbl_cls_t cls
);
  import pbl_pkg::*;

  // slot 0 is oldest; prefetches fill in order
  pbl_slot_t slot_q [SLOTS];
  logic [PBL_AW-1:0] sadr_q [SLOTS];
  logic [PBL_DW-1:0] sdat_q [SLOTS];
  logic [PBL_OWIDTH-1:0] out_q;
  logic [PBL_AW-1:0] last_q;
  pbl_state_t st_q;
  pbl_cmd_t hold_q;
  logic [$clog2(SLOTS)-1:0] hold_idx_q;
  logic [$clog2(SLOTS+1)-1:0] wp_q;

  function automatic logic in_seq(input logic [PBL_AW-1:0] a,
                                  input logic [PBL_AW-1:0] b);
    in_seq = (a == b + PBL_WORD_STEP);
  endfunction

  // parallel compare of all slots
  logic any_match;
  logic [$clog2(SLOTS)-1:0] midx;
  pbl_cls_t cls_c;
  logic seq_c;
  logic take;
  always_comb begin
    any_match = 1'b0;
    midx = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (!any_match && slot_q[i] != PBL_SLOT_EMPTY &&
          sadr_q[i] == cmd.addr) begin
        any_match = 1'b1;
        midx = i[$clog2(SLOTS)-1:0];
      end
    end
    seq_c = in_seq(cmd.addr, last_q);
    take = cmd.valid && cmd_ready && st_q == PBL_ST_IDLE;
    cls_c = PBL_CLS_NONE;
    if (take && !cmd.write) begin
      if (cmd.pf_able && any_match)
        cls_c = (slot_q[midx] == PBL_SLOT_LANDED) ? PBL_CLS_HIT
                                                 : PBL_CLS_HIT_WAIT;
      else
        cls_c = PBL_CLS_MISS;
    end
  end

  logic outst;
  assign outst = (out_q != PBL_CNT_RST);
  logic ack_all;
  assign ack_all = (out_q == PBL_CNT_RST) ||
                   (ack && ack_real && out_q == 4'h1);

  // classified action of the request being decided this cycle
  logic go_hit, go_upg, go_sub, go_hold, go_stall;
  logic wr_hit, inv_all, rel;
  always_comb begin
    go_hit = 1'b0;
    go_upg = 1'b0;
    go_sub = 1'b0;
    go_hold = 1'b0;
    go_stall = 1'b0;
    rel = 1'b0;
    wr_hit = take && cmd.write && any_match;
    case (st_q)
      PBL_ST_IDLE: begin
        case (cls_c)
          PBL_CLS_HIT: begin
            if (outst) go_stall = 1'b1;
            else go_hit = 1'b1;
          end
          PBL_CLS_HIT_WAIT: begin
            if (!outst || seq_c) go_upg = 1'b1;
            else go_hold = 1'b1;
          end
          PBL_CLS_MISS: begin
            if (!outst || (seq_c && !bank_busy && cmd.pf_able))
              go_sub = 1'b1;
            else go_hold = 1'b1;
          end
          default: ;
        endcase
      end
      PBL_ST_HIT_STALL: if (!outst || ack_all) rel = 1'b1;
      PBL_ST_HOLD: if (ack_all) rel = 1'b1;
      default: ;
    endcase
    inv_all = prefetch_flush_control || wr_hit ||
              (cls_c == PBL_CLS_MISS);
  end

  // request controller state and held command
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= PBL_ST_IDLE;
      hold_q <= '0;
      hold_idx_q <= '0;
    end else begin
      case (st_q)
        PBL_ST_IDLE: begin
          if (go_stall) begin
            st_q <= PBL_ST_HIT_STALL;
            hold_q <= cmd;
            hold_idx_q <= midx;
          end else if (go_hold) begin
            st_q <= PBL_ST_HOLD;
            hold_q <= cmd;
          end
        end
        PBL_ST_HIT_STALL, PBL_ST_HOLD: if (rel) st_q <= PBL_ST_IDLE;
        default: st_q <= PBL_ST_IDLE;
      endcase
    end
  end

  // stalled or held work blocks new commands and prefetches
  always_ff @(posedge mclk) begin
    if (!resetn) cmd_ready <= 1'b1;
    else cmd_ready <= (st_q == PBL_ST_IDLE) ? !(go_stall || go_hold)
                                            : rel;
  end

  // slots: fill, land on ack, invalidate
  logic pf_ack;
  assign pf_ack = ack && !ack_real;
  logic [$clog2(SLOTS)-1:0] land_idx;
  always_comb begin
    land_idx = '0;
    for (int i = SLOTS - 1; i >= 0; i--)
      if (slot_q[i] == PBL_SLOT_WAIT) land_idx = i[$clog2(SLOTS)-1:0];
  end
  logic hit_now;
  logic [$clog2(SLOTS)-1:0] hit_idx;
  logic hit_seq;
  assign hit_now = go_hit || (st_q == PBL_ST_HIT_STALL && rel);
  assign hit_idx = go_hit ? midx : hold_idx_q;
  assign hit_seq = go_hit ? seq_c : in_seq(hold_q.addr, last_q);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_q[i] <= PBL_SLOT_EMPTY;
        sadr_q[i] <= PBL_ADDR_RST;
        sdat_q[i] <= '0;
      end
      wp_q <= '0;
    end else if (inv_all) begin
      for (int i = 0; i < SLOTS; i++) slot_q[i] <= PBL_SLOT_EMPTY;
      wp_q <= '0;
    end else begin
      // data is landed in the same cycle as the ack; modelled as ack_data
      if (pf_ack && slot_q[land_idx] == PBL_SLOT_WAIT) begin
        slot_q[land_idx] <= PBL_SLOT_LANDED;
        sdat_q[land_idx] <= ack_data;
      end
      if (pf_issue && cmd_ready && wp_q < SLOTS[$clog2(SLOTS+1)-1:0]) begin
        slot_q[wp_q[$clog2(SLOTS)-1:0]] <= PBL_SLOT_WAIT;
        sadr_q[wp_q[$clog2(SLOTS)-1:0]] <= pf_addr;
        wp_q <= wp_q + 1'b1;
      end
      if (go_upg) slot_q[midx] <= PBL_SLOT_EMPTY;
      if (hit_now) begin
        for (int i = 0; i < SLOTS; i++)
          if (i == hit_idx || (!hit_seq && i < hit_idx))
            slot_q[i] <= PBL_SLOT_EMPTY;
      end
    end
  end

  // data select: buffered data one cycle after the hit
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (hit_now) begin
      rd_valid <= 1'b1;
      rd_data <= sdat_q[hit_idx];
    end else begin
      rd_valid <= ack && ack_real;
      rd_data <= ack_data;
    end
  end

  // outstanding real reads; real acks (ack with ack_real) retire them
  always_ff @(posedge mclk) begin
    if (!resetn) out_q <= PBL_CNT_RST;
    else out_q <= out_q + ((go_upg || go_sub ||
                            (st_q == PBL_ST_HOLD && rel)) ? 4'h1 : 4'h0)
                        - ((ack && ack_real) ? 4'h1 : 4'h0);
  end

  // bank request and upgrade outputs
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      breq <= '0;
      upg <= '0;
      pf_cancel <= 1'b0;
    end else begin
      breq <= '0;
      upg <= '0;
      pf_cancel <= wr_hit || prefetch_flush_control ||
                   (cls_c == PBL_CLS_MISS && !cmd.pf_able);
      if (go_sub) begin
        breq.valid <= 1'b1;
        breq.kind <= outst ? PBL_SUB_COND : PBL_SUB_UNCOND;
        breq.addr <= cmd.addr;
      end else if (st_q == PBL_ST_HOLD && rel) begin
        breq.valid <= 1'b1;
        breq.kind <= PBL_SUB_UNCOND;
        breq.addr <= hold_q.addr;
      end
      if (go_upg) begin
        upg.valid <= 1'b1;
        upg.cond <= outst;
        upg.addr <= cmd.addr;
      end
    end
  end

  // last real read, prefetch address and active flag
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      last_q <= PBL_ADDR_RST;
      pf_addr <= PBL_ADDR_RST;
      pf_active <= 1'b0;
    end else begin
      if (take && !cmd.write) last_q <= cmd.addr;
      if (take && !cmd.write && cmd.pf_able)
        pf_addr <= cmd.addr + PBL_WORD_STEP;
      else if (pf_issue && cmd_ready && wp_q < SLOTS[$clog2(SLOTS+1)-1:0])
        pf_addr <= pf_addr + PBL_WORD_STEP;
      if (wr_hit || prefetch_flush_control) pf_active <= 1'b0;
      else if (cls_c == PBL_CLS_MISS && cmd.pf_able) pf_active <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) cls <= PBL_CLS_NONE;
    else cls <= cls_c;
  end

  // checks
  a_hit_data_next: assert property (@(posedge mclk) disable iff (!resetn)
    go_hit |=> rd_valid) else $error("hit data not returned");
  a_stall_blocks: assert property (@(posedge mclk) disable iff (!resetn)
    go_stall |=> !cmd_ready) else $error("stall did not block");
  a_flush_clears: assert property (@(posedge mclk) disable iff (!resetn)
    prefetch_flush_control |=> !pf_active && slot_q[0] == PBL_SLOT_EMPTY)
    else $error("flush left state");
  a_wr_hit_cancel: assert property (@(posedge mclk) disable iff (!resetn)
    wr_hit |=> pf_cancel && !pf_active) else $error("write hit kept");
  a_miss_sets_act: assert property (@(posedge mclk) disable iff (!resetn)
    (cls_c == PBL_CLS_MISS && cmd.pf_able && !wr_hit &&
     !prefetch_flush_control) |=> pf_active)
    else $error("miss did not arm");
  a_miss_uncond: assert property (@(posedge mclk) disable iff (!resetn)
    (go_sub && !outst) |=> breq.valid && breq.kind == PBL_SUB_UNCOND)
    else $error("miss not unconditional");
  a_upg_cond: assert property (@(posedge mclk) disable iff (!resetn)
    go_upg |=> upg.valid && upg.cond == $past(outst))
    else $error("upgrade qualifier wrong");
  a_hold_submit: assert property (@(posedge mclk) disable iff (!resetn)
    (st_q == PBL_ST_HOLD && rel) |=> breq.valid)
    else $error("held request not sent");
  a_pf_step: assert property (@(posedge mclk) disable iff (!resetn)
    (take && !cmd.write && cmd.pf_able) |=>
    pf_addr == $past(cmd.addr) + PBL_WORD_STEP)
    else $error("prefetch address wrong");
  c_hit: cover property (@(posedge mclk) disable iff (!resetn) go_hit);
  c_stall: cover property (@(posedge mclk) disable iff (!resetn) go_stall);
  c_upg: cover property (@(posedge mclk) disable iff (!resetn) go_upg);
  c_hold: cover property (@(posedge mclk) disable iff (!resetn) go_hold);
endmodule // pbl_lookup
`default_nettype wire

/* File: sim/pbl_bank_model.sv */
// bank arbiter model answering real and prefetch requests in order
`timescale 1ns/1ps
`default_nettype none
module pbl_bank_model #(
  parameter int LAT = 3
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire pbl_pkg::pbl_breq_t breq,
  input wire pbl_pkg::pbl_upg_t upg,
  input wire logic pf_issue,
  input wire logic cmd_ready,
  input wire logic [pbl_pkg::PBL_AW-1:0] pf_addr,
  input wire logic stall,
  output logic ack,
  output logic ack_real,
  output logic [pbl_pkg::PBL_DW-1:0] ack_data
);
  import pbl_pkg::*;
  logic [PBL_AW:0] q_q[$];
  int wait_n;
  // oldest request wins after LAT cycles; stall models a slow arbiter
  always @(posedge mclk) begin
    if (!resetn) begin
      q_q.delete();
      wait_n = 0;
      ack <= 1'b0;
      ack_real <= 1'b0;
      ack_data <= '0;
    end else begin
      if (breq.valid)
        q_q.push_back({1'b1, breq.addr});
      if (pf_issue && cmd_ready)
        q_q.push_back({1'b0, pf_addr});
      // an upgraded prefetch is answered as a real request
      foreach (q_q[i])
        if (upg.valid && q_q[i][PBL_AW-1:0] == upg.addr)
          q_q[i][PBL_AW] = 1'b1;
      if (q_q.size() > 0 && !stall)
        wait_n++;
      if (q_q.size() > 0 && !stall && wait_n >= LAT) begin
        ack <= 1'b1;
        ack_real <= q_q[0][PBL_AW];
        ack_data <= {8{q_q[0][PBL_AW-1:0]}};
        void'(q_q.pop_front());
        wait_n = 0;
      end else begin
        ack <= 1'b0;
        ack_real <= 1'b0;
        // data lines change every cycle outside an ack
        ack_data <= ~ack_data;
      end
    end
  end
endmodule // pbl_bank_model
`default_nettype wire

/* File: sim/prefetch_buffer_lookup_tb.sv */
// self-checking bench for the prefetch buffer look-up block
`timescale 1ns/1ps
`default_nettype none
module prefetch_buffer_lookup_tb;
  import pbl_pkg::*;
  logic mclk, resetn, flush, busy, pf_issue, stall, ack, ack_real;
  logic cmd_ready, rd_valid, pf_cancel, pf_active;
  logic [PBL_DW-1:0] ack_data, rd_data;
  logic [PBL_AW-1:0] pf_addr;
  pbl_cmd_t cmd;
  pbl_breq_t breq;
  pbl_upg_t upg;
  pbl_cls_t cls;
  int err_count, check_count;
  localparam logic [PBL_AW-1:0] A = 32'h0000_0100;

  pbl_lookup uut (.mclk(mclk), .resetn(resetn), .cmd(cmd),
    .prefetch_flush_control(flush), .bank_busy(busy), .pf_issue(pf_issue),
    .ack(ack), .ack_real(ack_real), .ack_data(ack_data),
    .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .breq(breq), .upg(upg), .pf_cancel(pf_cancel), .pf_active(pf_active),
    .pf_addr(pf_addr), .cls(cls));
  pbl_bank_model bank (.mclk(mclk), .resetn(resetn), .breq(breq),
    .upg(upg), .pf_issue(pf_issue), .cmd_ready(cmd_ready),
    .pf_addr(pf_addr), .stall(stall), .ack(ack), .ack_real(ack_real),
    .ack_data(ack_data));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [PBL_DW-1:0] got, input logic [PBL_DW-1:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // one command, held for one taking edge; outputs checked on return
  task automatic send(input logic wr, input logic pfa, input logic [PBL_AW-1:0] a);
    @(negedge mclk);
    cmd <= '{valid: 1'b1, write: wr, pf_able: pfa, addr: a};
    @(negedge mclk);
    cmd.valid <= 1'b0;
  endtask

  // prefetch issued and left to land, bounded wait for the ack
  task automatic prefetch;
    int i;
    @(negedge mclk);
    pf_issue <= 1'b1;
    @(negedge mclk);
    pf_issue <= 1'b0;
    for (i = 0; i < 40 && ack !== 1'b1; i++)
      @(negedge mclk);
    if (ack !== 1'b1) begin
      err_count++;
      conclude();
    end
    @(negedge mclk);
  endtask

  task automatic drain;
    stall <= 1'b0;
    repeat (30) @(negedge mclk);
  endtask

  task automatic t_miss_hit;
    chk(cmd_ready, 1'b1);
    chk(pf_active, 1'b0);
    send(1'b0, 1'b1, A);
    chk(breq.valid, 1'b1);
    chk(breq.kind, PBL_SUB_UNCOND);
    chk(breq.addr, A);
    chk(cls, PBL_CLS_MISS);
    drain();
    chk(pf_active, 1'b1);
    chk(pf_addr, A + PBL_WORD_STEP);
    prefetch();
    send(1'b0, 1'b1, A + PBL_WORD_STEP);
    chk(rd_valid, 1'b1);
    chk(cls, PBL_CLS_HIT);
    chk(rd_data, {8{A + PBL_WORD_STEP}});
    chk(breq.valid, 1'b0);
  endtask

  task automatic t_hitwait;
    int i;
    drain();
    chk(pf_addr, A + 2 * PBL_WORD_STEP);
    stall <= 1'b1;
    @(negedge mclk);
    pf_issue <= 1'b1;
    @(negedge mclk);
    pf_issue <= 1'b0;
    send(1'b0, 1'b1, A + 2 * PBL_WORD_STEP);
    chk(upg.valid, 1'b1);
    chk(upg.cond, 1'b0);
    chk(upg.addr, A + 2 * PBL_WORD_STEP);
    chk(cls, PBL_CLS_HIT_WAIT);
    stall <= 1'b0;
    for (i = 0; i < 40 && rd_valid !== 1'b1; i++)
      @(negedge mclk);
    chk(rd_valid, 1'b1);
    if (rd_valid !== 1'b1) conclude();
    chk(rd_data, {8{A + 2 * PBL_WORD_STEP}});
  endtask

  task automatic t_sequence;
    int i;
    drain();
    stall <= 1'b1;
    send(1'b0, 1'b1, 32'h0000_3000);
    send(1'b0, 1'b1, 32'h0000_3020);
    chk(breq.kind, PBL_SUB_COND);
    send(1'b0, 1'b1, 32'h0000_5000);
    @(negedge mclk);
    chk(cmd_ready, 1'b0);
    chk(breq.valid, 1'b0);
    stall <= 1'b0;
    for (i = 0; i < 40 && breq.valid !== 1'b1; i++)
      @(negedge mclk);
    chk(breq.valid, 1'b1);
    if (breq.valid !== 1'b1) conclude();
    chk(breq.addr, 32'h0000_5000);
  endtask

  task automatic t_invalidate;
    drain();
    prefetch();
    send(1'b1, 1'b1, 32'h0000_7000);
    chk(pf_cancel, 1'b0);
    chk(pf_active, 1'b1);
    send(1'b1, 1'b1, 32'h0000_5020);
    chk(pf_cancel, 1'b1);
    chk(pf_active, 1'b0);
    send(1'b0, 1'b1, 32'h0000_6000);
    drain();
    @(negedge mclk);
    flush <= 1'b1;
    @(negedge mclk);
    flush <= 1'b0;
    chk(pf_active, 1'b0);
    send(1'b0, 1'b0, 32'h0000_8000);
    chk(breq.valid, 1'b1);
    chk(pf_cancel, 1'b1);
  endtask

  initial begin
    err_count = 0;
    check_count = 0;
    resetn = 1'b0;
    cmd = '0;
    flush = 1'b0;
    busy = 1'b0;
    pf_issue = 1'b0;
    stall = 1'b0;
    repeat (4) @(negedge mclk);
    resetn <= 1'b1;
    t_miss_hit();
    t_hitwait();
    t_sequence();
    t_invalidate();
    conclude();
  end
endmodule // prefetch_buffer_lookup_tb
`default_nettype wire
